// ### design/pesr_pkg.sv
package pesr_pkg;
   // data width of every status, enable and control register
   localparam int DW = 16;
   localparam int AW = 8;
   // event blocks: first and second primary, general zero, general one,
   // and one nested child block feeding a general zero parent bit
   localparam int NBLK = 5;
   localparam int BLK_PEV_A = 0;
   localparam int BLK_PEV_B = 1;
   localparam int BLK_GPE0 = 2;
   localparam int BLK_GPE1 = 3;
   localparam int BLK_CHILD = 4;
   // status offsets; each enable register sits one word above its status
   localparam logic [AW-1:0] STS_OFF [NBLK] =
      '{8'h00, 8'h08, 8'h20, 8'h28, 8'h30};
   localparam logic [AW-1:0] EN_OFF [NBLK] =
      '{8'h04, 8'h0C, 8'h24, 8'h2C, 8'h34};
   // implemented status/enable bits; first and second primary are disjoint
   localparam logic [DW-1:0] STS_IMPL [NBLK] =
      '{16'h0133, 16'h0400, 16'hFFFF, 16'h00FF, 16'h000F};
   localparam int GPE0_PARENT_BIT = 15;
   // control blocks of the primary grouping and the arbiter block
   localparam logic [AW-1:0] OFF_CTL_A = 8'h10;
   localparam logic [AW-1:0] OFF_CTL_B = 8'h14;
   localparam logic [AW-1:0] OFF_ARB = 8'h18;
   localparam logic [DW-1:0] CTL_IMPL_A = 16'h3C03;
   localparam logic [DW-1:0] CTL_IMPL_B = 16'h3C04;
   localparam logic [DW-1:0] CTL_PLAIN = 16'h0007;
   localparam int SLP_LSB = 10;
   localparam int SLP_W = 3;
   localparam int GO_BIT = 13;
   localparam int ARB_BIT = 0;
   localparam logic [DW-1:0] CTL_RST = 16'h0000;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;
   // sleep request handed to the power sequencer
   typedef struct packed {
      logic go;
      logic [SLP_W-1:0] type_a;
      logic [SLP_W-1:0] type_b;
   } pesr_sleep_t;
   // one decoded bus write
   typedef struct packed {
      logic fire;
      logic [AW-1:0] addr;
      logic [DW-1:0] data;
   } pesr_wr_t;
endpackage

// ### design/pesr_top.sv
`timescale 1ns/100ps
// Functional notes
// - event sets status; only written one clears
// - enable never touches status, only gates it
// - interrupt while any enabled status bit set; child only via parent
// - reserved bits read zero, writes ignored
// - grouping bit lives in A or B only
// - each event block has status plus enable
// - each primary control block has one register
// - arbiter block holds single arbiter disable bit
// - general events raise interrupt like fixed ones
// - child status feeds a general parent bit
// - general blocks use same clear and gating
// - block addresses fixed, never relocatable
// - write-only bit acts on written one
module pesr_top #(
   parameter logic [15:0] IMPL_PEV_A = pesr_pkg::STS_IMPL[0],
   parameter logic [15:0] IMPL_PEV_B = pesr_pkg::STS_IMPL[1],
   parameter logic [15:0] IMPL_CTL_A = pesr_pkg::CTL_IMPL_A,
   parameter logic [15:0] IMPL_CTL_B = pesr_pkg::CTL_IMPL_B
) (
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [pesr_pkg::AW-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [pesr_pkg::DW-1:0] EVT_PEV_A,
   input wire logic [pesr_pkg::DW-1:0] EVT_PEV_B,
   input wire logic [pesr_pkg::DW-1:0] EVT_GPE0,
   input wire logic [pesr_pkg::DW-1:0] EVT_GPE1,
   input wire logic [pesr_pkg::DW-1:0] EVT_CHILD,
   output logic SYSTEM_CONTROL_IRQ,
   output logic [pesr_pkg::DW-1:0] CTL_OUT,
   output pesr_pkg::pesr_sleep_t SLEEP,
   output logic ARB_DIS
);
   localparam int DW = pesr_pkg::DW;
   localparam int NBLK = pesr_pkg::NBLK;

   logic [DW-1:0] sts_ff [NBLK];
   logic [DW-1:0] en_ff [NBLK];
   logic [DW-1:0] nxt_sts [NBLK];
   logic [DW-1:0] nxt_en [NBLK];
   logic [DW-1:0] evt_in [NBLK];
   logic [DW-1:0] impl [NBLK];
   logic [DW-1:0] pend [NBLK];
   logic [DW-1:0] ctl_a_ff, ctl_b_ff, nxt_ctl_a, nxt_ctl_b;
   logic [DW-1:0] ctl_out_ff, nxt_ctl_out;
   logic arb_ff, nxt_arb, go_ff, nxt_go;
   logic irq_ff, pready_ff, pslverr_ff;
   logic [31:0] prdata_ff, rd_mux;
   logic setup, hit, any_pend, child_pend;
   pesr_pkg::pesr_wr_t wr;

   // address hit over every fixed block offset (no relocation possible)
   function automatic logic f_hit(input logic [pesr_pkg::AW-1:0] a);
      logic h;
      h = (a == pesr_pkg::OFF_CTL_A) || (a == pesr_pkg::OFF_CTL_B) ||
          (a == pesr_pkg::OFF_ARB);
      for (int k = 0; k < NBLK; k++) begin
         h = h || (a == pesr_pkg::STS_OFF[k]) || (a == pesr_pkg::EN_OFF[k]);
      end
      return h;
   endfunction

   // write strobe for one register
   function automatic logic f_wsel(input pesr_pkg::pesr_wr_t w,
                                   input logic [pesr_pkg::AW-1:0] off);
      return w.fire && (w.addr == off);
   endfunction

   // apb phases; the slave answers in the first access cycle
   assign setup = PSEL && !PENABLE;
   assign hit = f_hit(PADDR);
   assign wr.fire = PSEL && PENABLE && pready_ff && PWRITE && hit;
   assign wr.addr = PADDR;
   assign wr.data = PWDATA[DW-1:0];

   // implemented bit masks; A and B of a grouping do not overlap
   assign impl[pesr_pkg::BLK_PEV_A] = IMPL_PEV_A;
   assign impl[pesr_pkg::BLK_PEV_B] = IMPL_PEV_B;
   assign impl[pesr_pkg::BLK_GPE0] = pesr_pkg::STS_IMPL[2];
   assign impl[pesr_pkg::BLK_GPE1] = pesr_pkg::STS_IMPL[3];
   assign impl[pesr_pkg::BLK_CHILD] = pesr_pkg::STS_IMPL[4];

   // child pending feeds the general zero parent bit
   assign child_pend = |pend[pesr_pkg::BLK_CHILD];
   assign evt_in[pesr_pkg::BLK_PEV_A] = EVT_PEV_A;
   assign evt_in[pesr_pkg::BLK_PEV_B] = EVT_PEV_B;
   assign evt_in[pesr_pkg::BLK_GPE0] =
      EVT_GPE0 | (DW'(child_pend) << pesr_pkg::GPE0_PARENT_BIT);
   assign evt_in[pesr_pkg::BLK_GPE1] = EVT_GPE1;
   assign evt_in[pesr_pkg::BLK_CHILD] = EVT_CHILD;

   // one status/enable cell per block, identical model for all
   genvar g;
   generate
      for (g = 0; g < NBLK; g++) begin : g_blk
         logic [DW-1:0] clr;
         // written one clears, zero leaves alone
         assign clr = f_wsel(wr, pesr_pkg::STS_OFF[g]) ? wr.data : '0;
         // set wins over clear; unimplemented stay zero
         assign nxt_sts[g] = ((sts_ff[g] & ~clr) | evt_in[g]) & impl[g];
         assign nxt_en[g] = f_wsel(wr, pesr_pkg::EN_OFF[g]) ?
                            (wr.data & impl[g]) : en_ff[g];
         // enable only gates the event output
         assign pend[g] = sts_ff[g] & en_ff[g];
         always_ff @(posedge MCLK) begin
            if (!NRST) begin
               sts_ff[g] <= '0;
               en_ff[g] <= '0;
            end else begin
               sts_ff[g] <= nxt_sts[g];
               en_ff[g] <= nxt_en[g];
            end
         end
      end
   endgenerate

   // fixed and general events share the interrupt; child via parent
   assign any_pend = (|pend[pesr_pkg::BLK_PEV_A]) |
                     (|pend[pesr_pkg::BLK_PEV_B]) |
                     (|pend[pesr_pkg::BLK_GPE0]) |
                     (|pend[pesr_pkg::BLK_GPE1]);

   // one control register per primary block; own sleep code each
   assign nxt_ctl_a = f_wsel(wr, pesr_pkg::OFF_CTL_A) ?
                      (wr.data & IMPL_CTL_A) : ctl_a_ff;
   assign nxt_ctl_b = f_wsel(wr, pesr_pkg::OFF_CTL_B) ?
                      (wr.data & IMPL_CTL_B) : ctl_b_ff;
   // write-only go acts on a written one, from either block
   assign nxt_go = (f_wsel(wr, pesr_pkg::OFF_CTL_A) ||
                    f_wsel(wr, pesr_pkg::OFF_CTL_B)) &&
                   wr.data[pesr_pkg::GO_BIT];
   // the only bit of the arbiter block
   assign nxt_arb = f_wsel(wr, pesr_pkg::OFF_ARB) ?
                    wr.data[pesr_pkg::ARB_BIT] : arb_ff;
   // grouping output is the or of both blocks, registered so the pin
   // never shows a decode glitch between the two control writes
   assign nxt_ctl_out = (nxt_ctl_a | nxt_ctl_b) & pesr_pkg::CTL_PLAIN;

   // read mux; write-only go reads zero so software masks nothing odd
   always_comb begin
      rd_mux = pesr_pkg::RD_ZERO;
      for (int k = 0; k < NBLK; k++) begin
         if (PADDR == pesr_pkg::STS_OFF[k]) begin
            rd_mux[DW-1:0] = sts_ff[k];
         end
         if (PADDR == pesr_pkg::EN_OFF[k]) begin
            rd_mux[DW-1:0] = en_ff[k];
         end
      end
      if (PADDR == pesr_pkg::OFF_CTL_A) begin
         rd_mux[DW-1:0] = ctl_a_ff & ~(DW'(1) << pesr_pkg::GO_BIT);
      end
      if (PADDR == pesr_pkg::OFF_CTL_B) begin
         rd_mux[DW-1:0] = ctl_b_ff & ~(DW'(1) << pesr_pkg::GO_BIT);
      end
      if (PADDR == pesr_pkg::OFF_ARB) begin
         rd_mux[pesr_pkg::ARB_BIT] = arb_ff;
      end
   end

   // control state, go pulse and interrupt
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         ctl_a_ff <= pesr_pkg::CTL_RST;
         ctl_b_ff <= pesr_pkg::CTL_RST;
         arb_ff <= 1'b0;
         go_ff <= 1'b0;
         irq_ff <= 1'b0;
         ctl_out_ff <= pesr_pkg::CTL_RST;
      end else begin
         ctl_a_ff <= nxt_ctl_a;
         ctl_b_ff <= nxt_ctl_b;
         arb_ff <= nxt_arb;
         go_ff <= nxt_go;
         irq_ff <= any_pend;
         ctl_out_ff <= nxt_ctl_out;
      end
   end

   // apb answer captured in setup; pready high for exactly the access cycle
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= pesr_pkg::RD_ZERO;
      end else begin
         pready_ff <= setup;
         pslverr_ff <= setup && !hit;
         prdata_ff <= (setup && !PWRITE) ? rd_mux : pesr_pkg::RD_ZERO;
      end
   end

   // outputs; grouping control bits are the OR of both blocks
   assign PRDATA = prdata_ff;
   assign PREADY = pready_ff;
   assign PSLVERR = pslverr_ff;
   assign SYSTEM_CONTROL_IRQ = irq_ff;
   assign ARB_DIS = arb_ff;
   assign CTL_OUT = ctl_out_ff;
   assign SLEEP.go = go_ff;
   assign SLEEP.type_a = ctl_a_ff[pesr_pkg::SLP_LSB +: pesr_pkg::SLP_W];
   assign SLEEP.type_b = ctl_b_ff[pesr_pkg::SLP_LSB +: pesr_pkg::SLP_W];

   // checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!NRST);

   logic clr_a0, arb_wdat;
   assign clr_a0 = f_wsel(wr, pesr_pkg::STS_OFF[0]) && wr.data[0];
   assign arb_wdat = wr.data[pesr_pkg::ARB_BIT];

   sequence s_go_write;
      f_wsel(wr, pesr_pkg::OFF_CTL_A) && wr.data[pesr_pkg::GO_BIT];
   endsequence
   sequence s_go_pulse;
      SLEEP.go ##1 !SLEEP.go;
   endsequence

   property p_set;
      EVT_PEV_A[0] |=> sts_ff[0][0];
   endproperty
   a_set: assert property (p_set) else $error("event did not set");
   property p_hold;
      sts_ff[0][0] && !clr_a0 |=> sts_ff[0][0];
   endproperty
   a_hold: assert property (p_hold) else $error("status lost");
   property p_clr;
      clr_a0 && !EVT_PEV_A[0] |=> !sts_ff[0][0];
   endproperty
   a_clr: assert property (p_clr) else $error("clear ignored");
   property p_en_free;
      EVT_GPE1[0] && !en_ff[3][0] && !f_wsel(wr, pesr_pkg::EN_OFF[3]) |=>
         sts_ff[3][0] && !pend[3][0];
   endproperty
   a_en_free: assert property (p_en_free) else $error("enable gated");
   property p_irq;
      any_pend |=> SYSTEM_CONTROL_IRQ;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing");
   property p_irq_off;
      !any_pend |=> !SYSTEM_CONTROL_IRQ;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("stray irq");
   property p_rsv;
      PSEL && PENABLE && PREADY && !PWRITE &&
      PADDR == pesr_pkg::STS_OFF[0] |-> (PRDATA[15:0] & ~IMPL_PEV_A) == 0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved nonzero");
   property p_arb;
      f_wsel(wr, pesr_pkg::OFF_ARB) |=> ARB_DIS == $past(arb_wdat);
   endproperty
   a_arb: assert property (p_arb) else $error("arbiter bit");
   property p_nest;
      child_pend |=> sts_ff[2][pesr_pkg::GPE0_PARENT_BIT];
   endproperty
   a_nest: assert property (p_nest) else $error("parent not set");
   property p_race;
      clr_a0 && EVT_PEV_A[0] |=> sts_ff[0][0];
   endproperty
   a_race: assert property (p_race) else $error("event lost");
   property p_go;
      s_go_write |=> s_go_pulse;
   endproperty
   a_go: assert property (p_go) else $error("go pulse wrong");
   property p_ready;
      PSEL && !PENABLE |=> PREADY ##1 !PREADY;
   endproperty
   a_ready: assert property (p_ready) else $error("pready timing");

   // register file guards: reserved bits, refused accesses, sleep codes
   logic [pesr_pkg::SLP_W-1:0] slp_wdat;
   logic err_wr;
   assign slp_wdat = wr.data[pesr_pkg::SLP_LSB +: pesr_pkg::SLP_W];
   assign err_wr = PSEL && PENABLE && PREADY && PWRITE && !hit;

   // a refused write, then every control register left as it was
   sequence s_refused_write;
      err_wr;
   endsequence
   sequence s_ctl_kept;
      $stable(arb_ff) && $stable(ctl_a_ff) && $stable(ctl_b_ff);
   endsequence

   // general events, grouping output and refused accesses
   property p_gen_irq;
      (|pend[pesr_pkg::BLK_GPE1]) |=> SYSTEM_CONTROL_IRQ;
   endproperty
   a_gen_irq: assert property (p_gen_irq) else $error("general irq");
   property p_ctl_or;
      CTL_OUT == ((ctl_a_ff | ctl_b_ff) & pesr_pkg::CTL_PLAIN);
   endproperty
   a_ctl_or: assert property (p_ctl_or) else $error("grouping or");
   property p_err_rd;
      PSLVERR |-> PREADY && PRDATA == pesr_pkg::RD_ZERO;
   endproperty
   a_err_rd: assert property (p_err_rd) else $error("refused read");
   property p_err_wr;
      s_refused_write |=> s_ctl_kept;
   endproperty
   a_err_wr: assert property (p_err_wr) else $error("refused write");
   property p_go_rd;
      PSEL && PENABLE && PREADY && !PWRITE &&
      PADDR == pesr_pkg::OFF_CTL_A |-> !PRDATA[pesr_pkg::GO_BIT];
   endproperty
   a_go_rd: assert property (p_go_rd) else $error("go bit read back");
   property p_slp_a;
      f_wsel(wr, pesr_pkg::OFF_CTL_A) |=> SLEEP.type_a == $past(slp_wdat);
   endproperty
   a_slp_a: assert property (p_slp_a) else $error("sleep code a");
   property p_slp_b;
      f_wsel(wr, pesr_pkg::OFF_CTL_B) |=> SLEEP.type_b == $past(slp_wdat);
   endproperty
   a_slp_b: assert property (p_slp_b) else $error("sleep code b");
   property p_en_rsv;
      (en_ff[pesr_pkg::BLK_PEV_A] & ~IMPL_PEV_A) == '0 &&
      (en_ff[pesr_pkg::BLK_PEV_B] & ~IMPL_PEV_B) == '0;
   endproperty
   a_en_rsv: assert property (p_en_rsv) else $error("reserved enable");
   property p_ctl_rsv;
      (ctl_a_ff & ~IMPL_CTL_A) == '0 && (ctl_b_ff & ~IMPL_CTL_B) == '0;
   endproperty
   a_ctl_rsv: assert property (p_ctl_rsv) else $error("reserved ctl");
   property p_en_kept;
      f_wsel(wr, pesr_pkg::STS_OFF[0]) |=> $stable(en_ff[0]);
   endproperty
   a_en_kept: assert property (p_en_kept) else $error("enable moved");
   property p_arb_kept;
      !f_wsel(wr, pesr_pkg::OFF_ARB) |=> $stable(ARB_DIS);
   endproperty
   a_arb_kept: assert property (p_arb_kept) else $error("arb moved");
endmodule

// ### sim/pesr_tb_top.sv
`timescale 1ns/100ps
module pesr_tb_top;
   logic MCLK = 1'b0;
   logic NRST = 1'b0;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0000_0000;
   logic [31:0] PRDATA;
   logic PREADY;
   logic PSLVERR;
   logic [15:0] ev [5] = '{default: 16'h0000};
   logic SYSTEM_CONTROL_IRQ;
   logic [15:0] CTL_OUT;
   pesr_pkg::pesr_sleep_t SLEEP;
   logic ARB_DIS;
   int mismatches = 0;
   int samples_checked = 0;
   int cycles = 0;
   int gos = 0;
   logic [31:0] rd;
   logic [31:0] rd_a;
   logic err;
   // rows: address, write value, expected readback
   logic [39:0] rows [10] = '{40'h04_FFFF_0133, 40'h0C_FFFF_0400,
      40'h24_FFFF_FFFF, 40'h2C_FFFF_00FF, 40'h34_FFFF_000F,
      40'h10_FFFF_1C03, 40'h14_FFFF_1C04, 40'h18_FFFF_0001,
      40'h00_FFFF_0000, 40'h20_FFFF_0000};

   always #10 MCLK = ~MCLK;

   pesr_top pesr_top_i (.MCLK(MCLK), .NRST(NRST), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .EVT_PEV_A(ev[0]), .EVT_PEV_B(ev[1]), .EVT_GPE0(ev[2]),
      .EVT_GPE1(ev[3]), .EVT_CHILD(ev[4]),
      .SYSTEM_CONTROL_IRQ(SYSTEM_CONTROL_IRQ),
      .CTL_OUT(CTL_OUT), .SLEEP(SLEEP), .ARB_DIS(ARB_DIS));

   // cycle ceiling, far above the fewer than two hundred cycles the run needs
   always @(posedge MCLK) begin
      cycles <= cycles + 1;
      if (SLEEP.go === 1'b1) gos <= gos + 1;
      if (cycles == 3000) begin
         mismatches = mismatches + 1;
         final_report();
      end
   end

   task automatic final_report;
      if (mismatches == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string m);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %0t %s got %h want %h", $time, m, got, exp);
      end
   endtask

   // one apb transfer; an idle edge after it keeps drivers apart
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [15:0] d);
      int n;
      n = 0;
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= {16'h0000, d};
      @(posedge MCLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge MCLK);
         n++;
      end while (PREADY !== 1'b1 && n < 16);
      if (n == 16) chk(32'h0, 32'h1, "no ready");
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge MCLK);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [15:0] e,
                      input string m);
      apb(1'b0, a, 16'h0000);
      chk(rd, {16'h0000, e}, m);
   endtask

   // one-cycle event pulse on the selected blocks
   task automatic pulse(input logic [4:0] s, input logic [15:0] v);
      foreach (ev[i]) if (s[i]) ev[i] <= v;
      @(posedge MCLK);
      foreach (ev[i]) ev[i] <= 16'h0000;
      @(posedge MCLK);
   endtask

   initial begin
      repeat (5) @(posedge MCLK);
      NRST <= 1'b1;
      @(posedge MCLK);
      // table walk: write all ones, read back readable implemented bits, zero from status rows
      foreach (rows[i]) begin
         apb(1'b1, rows[i][39:32], rows[i][31:16]);
         rdc(rows[i][39:32], rows[i][15:0], "row");
      end
      chk({16'h0000, CTL_OUT}, 32'h7, "ctl");
      chk({31'h0, ARB_DIS}, 32'h1, "arb");
      chk(gos, 32'h2, "go");
      chk({26'h0, SLEEP.type_a, SLEEP.type_b}, 32'h3F, "slp");
      // grouping read: a then b, or them, drop the sleep code
      apb(1'b0, 8'h10, 16'h0000);
      rd_a = rd;
      apb(1'b0, 8'h14, 16'h0000);
      chk((rd_a | rd) & 32'hFFFF_E3FF, 32'h7, "grp");
      // every event line at once, all enables open
      pulse(5'h1F, 16'hFFFF);
      rdc(8'h00, 16'h0133, "sa");
      rdc(8'h08, 16'h0400, "sb");
      rdc(8'h20, 16'hFFFF, "g0");
      rdc(8'h28, 16'h00FF, "g1");
      rdc(8'h30, 16'h000F, "ch");
      chk({31'h0, SYSTEM_CONTROL_IRQ}, 32'h1, "irq");
      // zeros keep; parent re-sets while the child still pends
      apb(1'b1, 8'h00, 16'h0000);
      rdc(8'h00, 16'h0133, "w0");
      for (int i = 0; i < 4; i++) apb(1'b1, pesr_pkg::STS_OFF[i], 16'hFFFF);
      rdc(8'h20, 16'h8000, "par");
      apb(1'b1, 8'h30, 16'hFFFF);
      apb(1'b1, 8'h20, 16'h8000);
      rdc(8'h20, 16'h0000, "pc");
      chk({31'h0, SYSTEM_CONTROL_IRQ}, 32'h0, "irq0");
      // masked event still latches but stays silent
      apb(1'b1, 8'h04, 16'h0000);
      apb(1'b1, 8'h2C, 16'h0000);
      pulse(5'h09, 16'h0001);
      rdc(8'h00, 16'h0001, "msk");
      rdc(8'h28, 16'h0001, "msk1");
      chk({31'h0, SYSTEM_CONTROL_IRQ}, 32'h0, "mirq");
      apb(1'b1, 8'h04, 16'h0001);
      @(posedge MCLK);
      chk({31'h0, SYSTEM_CONTROL_IRQ}, 32'h1, "eirq");
      // event lands on the very edge of the clearing write
      fork
         apb(1'b1, 8'h00, 16'h0001);
         begin
            @(posedge MCLK);
            ev[0] <= 16'h0001;
            @(posedge MCLK);
            ev[0] <= 16'h0000;
         end
      join
      rdc(8'h00, 16'h0001, "race");
      // different sleep codes per block, plain bits cleared
      apb(1'b1, 8'h10, 16'h1400);
      apb(1'b1, 8'h14, 16'h0800);
      chk({26'h0, SLEEP.type_a, SLEEP.type_b}, 32'h2A, "slp2");
      chk({16'h0000, CTL_OUT}, 32'h0, "ctl0");
      // unmapped places refuse
      apb(1'b1, 8'h1C, 16'hFFFF);
      chk({31'h0, err}, 32'h1, "werr");
      apb(1'b0, 8'h3C, 16'h0000);
      chk({err, rd[30:0]}, 32'h8000_0000, "rerr");
      // second reset in mid-run
      NRST <= 1'b0;
      repeat (2) @(posedge MCLK);
      NRST <= 1'b1;
      @(posedge MCLK);
      chk({CTL_OUT, 7'h00, SYSTEM_CONTROL_IRQ, SLEEP, ARB_DIS}, 32'h0,
          "rst");
      rdc(8'h00, 16'h0000, "rsts");
      rdc(8'h04, 16'h0000, "rsten");
      final_report();
   end
endmodule
